// ---- hdl/prel_consts.svh ----
// constants for the processor reset entry logic
`ifndef PREL_CONSTS_SVH
`define PREL_CONSTS_SVH
`define PREL_SYNC_STAGES 2
`define PREL_UPPER_W     3
`define PREL_UPPER_ONES  3'h7
`define PREL_CTL_W       4
`define PREL_CTL_IDLE    4'hf
`define PREL_PHASE_W     2
`endif

// ---- hdl/prel_pkg.sv ----
// types for the processor reset entry logic
`include "prel_consts.svh"
package prel_pkg;
  typedef enum logic [1:0] {
    PREL_RUN   = 2'b00,
    PREL_DRIVE = 2'b01,
    PREL_FLOAT = 2'b10
  } prel_state_t;
endpackage

// ---- hdl/prel_reset_entry.sv ----
// reset entry: request sync, bus abort, pin turnaround and strap capture
`timescale 1ns/1ps
`include "prel_consts.svh"

// Notes on behaviour
// - reset request low forces reset always
// - request synchronised on own clock first
// - reset returns sequencing to defined state
// - abort bus: drive inactive, then float
// - lock, strap, upper address become pulled inputs
// - only strap low allowed; selects float mode
module prel_reset_entry (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      reset_request_n,
  input  wire logic                      busCycleActive,
  input  wire logic [`PREL_CTL_W-1:0]    busCtlActive,
  input  wire logic                      lockActive,
  input  wire logic [`PREL_UPPER_W-1:0]  upperAddrActive,
  input  wire logic                      topAddrActive,
  input  wire logic                      top_addr_mode_strap_in,
  output logic                           coreReset,
  output logic                           busAbort,
  output logic [`PREL_CTL_W-1:0]         busCtlOut,
  output logic                           busCtlOe,
  output logic                           lockOut,
  output logic                           lockOe,
  output logic                           lockPullup,
  output logic [`PREL_UPPER_W-1:0]       upper_addr_pins_out,
  output logic                           upperAddrOe,
  output logic                           upperAddrPullup,
  output logic                           top_addr_mode_strap_out,
  output logic                           topAddrOe,
  output logic                           topAddrPullup,
  output logic                           test_float_mode
);
  import prel_pkg::*;

  logic        reqSync;
  logic        strapS1_r;
  logic        strapS2_r;
  logic        reqDly_r;
  prel_state_t state_r;
  prel_state_t state_nxt;
  logic        coreReset_r;
  logic        coreReset_nxt;
  logic        busAbort_r;
  logic        busAbort_nxt;
  logic [`PREL_CTL_W-1:0] busCtlOut_r;
  logic [`PREL_CTL_W-1:0] busCtlOut_nxt;
  logic        busCtlOe_r;
  logic        busCtlOe_nxt;
  logic        lockOut_r;
  logic        lockOut_nxt;
  logic        pinOe_r;
  logic        pinOe_nxt;
  logic        pullUp_r;
  logic        pullUp_nxt;
  logic [`PREL_UPPER_W-1:0] upperOut_r;
  logic [`PREL_UPPER_W-1:0] upperOut_nxt;
  logic        topOut_r;
  logic        topOut_nxt;
  logic        floatMode_r;
  logic        floatMode_nxt;
  logic        inReset;
  logic        release_w;

  // pin enters through two flops; core only sees the synced level
  prel_sync u_req_sync (
    .clk     (clk),
    .asyncIn (reset_request_n),
    .syncOut (reqSync)
  );

  // local reset or synced pin request, whichever comes first
  assign inReset   = !reset_n || !reqSync;
  assign release_w = reqDly_r && reqSync && reset_n;

  always_comb begin
    state_nxt     = state_r;
    coreReset_nxt = 1'b0;
    busAbort_nxt  = 1'b0;
    busCtlOut_nxt = busCtlActive;
    busCtlOe_nxt  = 1'b1;
    lockOut_nxt   = lockActive;
    pinOe_nxt     = 1'b1;
    upperOut_nxt  = upperAddrActive;
    topOut_nxt    = topAddrActive;
    floatMode_nxt = floatMode_r;
    // strap is sampled on the cycle the synced request goes high
    if (!reqDly_r && reqSync && reset_n) begin
      floatMode_nxt = !strapS2_r;
    end
    if (inReset) begin
      coreReset_nxt = 1'b1;
      pinOe_nxt     = 1'b0;
      lockOut_nxt   = 1'b1;
      upperOut_nxt  = `PREL_UPPER_ONES;
      topOut_nxt    = 1'b1;
      case (state_r)
        PREL_RUN: begin
          // one cycle of inactive drive before letting go of the bus
          state_nxt     = PREL_DRIVE;
          busAbort_nxt  = busCycleActive;
          busCtlOut_nxt = `PREL_CTL_IDLE;
          busCtlOe_nxt  = 1'b1;
        end
        PREL_DRIVE: begin
          state_nxt     = PREL_FLOAT;
          busCtlOut_nxt = `PREL_CTL_IDLE;
          busCtlOe_nxt  = 1'b0;
        end
        default: begin
          state_nxt     = PREL_FLOAT;
          busCtlOut_nxt = `PREL_CTL_IDLE;
          busCtlOe_nxt  = 1'b0;
        end
      endcase
    end else begin
      state_nxt = PREL_RUN;
    end
    if (!reset_n) begin
      floatMode_nxt = 1'b0;
    end
    // pullup enable registered so the pin control leaves a flop directly
    pullUp_nxt = !pinOe_nxt;
  end

  always_ff @(posedge clk) begin
    strapS1_r <= top_addr_mode_strap_in;
    strapS2_r <= strapS1_r;
    if (!reset_n) begin
      reqDly_r    <= 1'b0;
      state_r     <= PREL_RUN;
      coreReset_r <= 1'b1;
      busAbort_r  <= 1'b0;
      busCtlOut_r <= `PREL_CTL_IDLE;
      busCtlOe_r  <= 1'b0;
      lockOut_r   <= 1'b1;
      pinOe_r     <= 1'b0;
      pullUp_r    <= 1'b1;
      upperOut_r  <= `PREL_UPPER_ONES;
      topOut_r    <= 1'b1;
      floatMode_r <= 1'b0;
    end else begin
      reqDly_r    <= reqSync;
      state_r     <= state_nxt;
      coreReset_r <= coreReset_nxt;
      busAbort_r  <= busAbort_nxt;
      busCtlOut_r <= busCtlOut_nxt;
      busCtlOe_r  <= busCtlOe_nxt;
      lockOut_r   <= lockOut_nxt;
      pinOe_r     <= pinOe_nxt;
      pullUp_r    <= pullUp_nxt;
      upperOut_r  <= upperOut_nxt;
      topOut_r    <= topOut_nxt;
      floatMode_r <= floatMode_nxt;
    end
  end

  assign coreReset               = coreReset_r;
  assign busAbort                = busAbort_r;
  assign busCtlOut               = busCtlOut_r;
  assign busCtlOe                = busCtlOe_r;
  assign lockOut                 = lockOut_r;
  assign lockOe                  = pinOe_r;
  // pullups sit on exactly when the drivers are off
  assign lockPullup              = pullUp_r;
  assign upper_addr_pins_out     = upperOut_r;
  assign upperAddrOe             = pinOe_r;
  assign upperAddrPullup         = pullUp_r;
  assign top_addr_mode_strap_out = topOut_r;
  assign topAddrOe               = pinOe_r;
  assign topAddrPullup           = pullUp_r;
  assign test_float_mode         = floatMode_r;

  sequence reqSeenLow;
    !reqSync;
  endsequence

  sequence busDropped;
    busCtlOe_r && (busCtlOut_r == `PREL_CTL_IDLE) ##1 !busCtlOe_r;
  endsequence

  chk_req_forces_reset: assert property (@(posedge clk) disable iff (!reset_n)
    reqSeenLow |=> coreReset) else $error("core not reset on request");

  chk_sync_two_flops: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(reset_request_n) ##1 !reset_request_n ##1 !reset_request_n |=> coreReset)
    else $error("synced request not acted on");

  chk_reset_clears_state: assert property (@(posedge clk) disable iff (!reset_n)
    reqSeenLow ##1 !reqSync |=> (state_r != PREL_RUN))
    else $error("sequencer not held in reset");

  chk_abort_then_float: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(reqSync) |=> busDropped) else $error("bus not idled then floated");

  chk_abort_flag: assert property (@(posedge clk) disable iff (!reset_n)
    ($fell(reqSync) && busCycleActive && state_r == PREL_RUN) |=> busAbort)
    else $error("bus cycle not aborted");

  chk_float_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == PREL_FLOAT) |-> !busCtlOe)
    else $error("bus control driven while floated");

  chk_pins_inputs: assert property (@(posedge clk) disable iff (!reset_n)
    reqSeenLow |=> (!lockOe && !upperAddrOe && !topAddrOe && lockPullup && topAddrPullup))
    else $error("pins not turned to pulled inputs");

  chk_run_pins_follow: assert property (@(posedge clk) disable iff (!reset_n)
    !inReset |=> (lockOut == $past(lockActive)
      && upper_addr_pins_out == $past(upperAddrActive)
      && top_addr_mode_strap_out == $past(topAddrActive)))
    else $error("pins not following core in run");

  chk_strap_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (!reqDly_r && reqSync) |=> (test_float_mode == !$past(strapS2_r)))
    else $error("strap not latched at release");

  chk_mode_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (reqDly_r && reqSync) |=> $stable(test_float_mode))
    else $error("float mode changed outside release");

  chk_run_drives: assert property (@(posedge clk) disable iff (!reset_n)
    release_w |=> (lockOe && topAddrOe && !coreReset))
    else $error("pins not driven after release");
endmodule

// ---- hdl/prel_sync.sv ----
// two-flop synchroniser for the reset request pin
`timescale 1ns/1ps
module prel_sync (
  input  wire logic clk,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_r;
  logic stage2_r;
  logic stage1_nxt;
  logic stage2_nxt;

  always_comb begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
  end

  // no reset: this flop chain carries the reset itself
  always_ff @(posedge clk) begin
    stage1_r <= stage1_nxt;
    stage2_r <= stage2_nxt;
  end

  assign syncOut = stage2_r;
endmodule

// ---- verif/prel_board_model.sv ----
// board model: reset source and strap pull on the top address pin
`timescale 1ns/1ps
module prel_board_model (
  input  wire logic clk,
  input  wire logic holdReq,
  input  wire logic strapLow,
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic pinPullup,
  output logic      reset_request_n,
  output logic      strapPin
);
  logic lastLevel;
  // request held low from power-on until the bench lets go
  assign reset_request_n = !holdReq;
  // only the strap pin is ever pulled low; lock and upper address left alone
  always_comb begin
    if (pinOe)
      strapPin = pinOut;
    else if (strapLow)
      strapPin = 1'b0;
    else if (pinPullup)
      strapPin = 1'b1;
    else
      strapPin = !lastLevel;
  end
  always_ff @(posedge clk) lastLevel <= strapPin;
endmodule

// ---- verif/processor_reset_entry_logic_test.sv ----
// self-checking bench for the processor reset entry logic
`timescale 1ns/1ps
module processor_reset_entry_logic_test;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       holdReq = 1'b1;
  logic       strapLow = 1'b0;
  logic       cyc = 1'b0;
  logic       lockA = 1'b1;
  logic       topA = 1'b1;
  logic [3:0] ctlA = 4'hf;
  logic [2:0] upA = 3'h7;
  logic       reqN, strap, coreReset, busAbort, busCtlOe, lockOut, lockOe, lockPullup;
  logic       upperAddrOe, upperAddrPullup, topOut, topAddrOe, topAddrPullup, floatMode;
  logic [3:0] busCtlOut;
  logic [2:0] upOut;
  int         n_mismatch = 0;
  int         checks_done = 0;
  bit         expFloat = 1'b0;
  bit         strapQ[$];

  always #20 clk = ~clk;

  prel_board_model board (.clk(clk), .holdReq(holdReq), .strapLow(strapLow), .pinOut(topOut),
    .pinOe(topAddrOe), .pinPullup(topAddrPullup), .reset_request_n(reqN), .strapPin(strap));

  prel_reset_entry uut (.clk(clk), .reset_n(reset_n), .reset_request_n(reqN),
    .busCycleActive(cyc), .busCtlActive(ctlA), .lockActive(lockA), .upperAddrActive(upA),
    .topAddrActive(topA), .top_addr_mode_strap_in(strap), .coreReset(coreReset),
    .busAbort(busAbort), .busCtlOut(busCtlOut), .busCtlOe(busCtlOe), .lockOut(lockOut),
    .lockOe(lockOe), .lockPullup(lockPullup), .upper_addr_pins_out(upOut),
    .upperAddrOe(upperAddrOe), .upperAddrPullup(upperAddrPullup),
    .top_addr_mode_strap_out(topOut), .topAddrOe(topAddrOe),
    .topAddrPullup(topAddrPullup), .test_float_mode(floatMode));

  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic edges(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // warm entry and exit; the strap choice is random so both modes get latched
  task automatic warm(bit pull);
    cyc = 1'($urandom);
    ctlA = 4'($urandom);
    lockA = 1'($urandom);
    upA = 3'($urandom);
    topA = 1'($urandom);
    holdReq = 1'b1;
    strapLow = pull;
    edges(2);
    chk("sync", 4'h0, coreReset);
    edges(1);
    chk("core", 4'h1, coreReset);
    chk("float kept", 4'(expFloat), floatMode);
    chk("abort", 4'(cyc), busAbort);
    chk("ctl idle", 4'hf, busCtlOut);
    chk("ctl oe", 4'h1, busCtlOe);
    chk("pins oe", 4'h0, {lockOe, upperAddrOe, topAddrOe});
    chk("pullups", 4'h7, {lockPullup, upperAddrPullup, topAddrPullup});
    edges(1);
    chk("ctl float", 4'h0, busCtlOe);
    chk("abort end", 4'h0, busAbort);
    edges(4);
    // strap kept steady well around the release edge
    holdReq = 1'b0;
    strapQ.push_back(pull);
    edges(3);
    expFloat = strapQ.pop_front();
    chk("core run", 4'h0, coreReset);
    chk("float mode", 4'(expFloat), floatMode);
    chk("ctl run", ctlA, busCtlOut);
    chk("ctl oe run", 4'h1, busCtlOe);
    chk("lock run", 4'(lockA), lockOut);
    chk("upper run", 4'(upA), upOut);
    chk("top run", 4'(topA), topOut);
    chk("pins oe run", 4'h7, {lockOe, upperAddrOe, topAddrOe});
    chk("pullups off", 4'h0, {lockPullup, upperAddrPullup, topAddrPullup});
    // strap let go three clocks after release, while the pin is driven again
    strapLow = 1'b0;
    edges(4);
  endtask

  initial begin
    void'($urandom(14));
    edges(4);
    reset_n = 1'b1;
    edges(3);
    chk("held", 4'h1, coreReset);
    holdReq = 1'b0;
    edges(4);
    chk("cold float", 4'h0, floatMode);
    $display("test cold reset done");
    for (int i = 0; i < 8; i++) begin
      warm(i[0] ^ 1'($urandom));
      $display("test warm reset %0d done", i);
    end
    // local reset mid-run clears the mode; strap re-read as it lets go
    reset_n = 1'b0;
    strapLow = 1'($urandom);
    edges(1);
    chk("local core", 4'h1, coreReset);
    chk("local clear", 4'h0, floatMode);
    edges(3);
    reset_n = 1'b1;
    strapQ.push_back(strapLow);
    edges(2);
    expFloat = strapQ.pop_front();
    chk("local run", 4'h0, coreReset);
    chk("local float", 4'(expFloat), floatMode);
    $display("test local reset done");
    wrap_up();
  end

  initial begin
    #(40 * 600);
    n_mismatch++;
    wrap_up();
  end
endmodule
